// ---- power_state_sequencer_bench.sv ----
// Self-checking bench for the power state sequencer driven by the host model.
// Assumes pss_pkg, the sequencer, the host model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module power_state_sequencer_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, sys_reset_n, seq_busy;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        supply_above_por = 1'b1, system_supply_ok = 1'b1, power_on_n = 1'b1;
    logic        watchdog_expired = 1'b0, gpio_dvs_req = 1'b0, gpio_sleep_req = 1'b0;
    logic        otp_valid = 1'b1, eeprom_present = 1'b1, eeprom_valid = 1'b1;
    logic [31:0] otp_on_slot = 32'h0000_0011, otp_slp_slot = 32'h0000_0001;
    logic [31:0] eeprom_on_slot = 32'h0054_3210, eeprom_slp_slot = 32'h0000_0000;
    logic [1:0]  gpio_ext_enable;
    logic [7:0]  rail_enable, dvs_level;
    logic        alive_domain_regulator_en, internal_core_supply_regulator_en;
    logic [2:0]  power_state;
    int          num_errors = 0;
    int          comparisons = 0;
    always #50 pclk = ~pclk;
    pss_sequencer #(.RTC_DIV(16)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .supply_above_por, .system_supply_ok, .power_on_n,
        .watchdog_expired, .otp_valid, .otp_on_slot, .otp_slp_slot, .eeprom_present,
        .eeprom_valid, .eeprom_on_slot, .eeprom_slp_slot, .gpio_dvs_req, .gpio_sleep_req,
        .gpio_ext_enable, .rail_enable, .alive_domain_regulator_en,
        .internal_core_supply_regulator_en, .dvs_level, .sys_reset_n, .power_state, .seq_busy);
    pss_host host (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
        logic [31:0] q;
        logic        e;
        host.xfer(w, a, d, q, e);
        chk("slave error", {31'h0, err}, {31'h0, e});
        if (!w && !err)
            chk("read data", d, q);
    endtask
    // Polls rails (sel low) or state (sel high) until it shows exp, or gives up.
    task automatic wait_eq(input logic sel, input logic [7:0] exp);
        int n;
        n = 0;
        while ((sel ? {5'h0, power_state} : rail_enable) !== exp && n < 400)
        begin
            @(posedge pclk);
            n++;
        end
        chk(sel ? "state" : "rails", {24'h0, exp}, {24'h0, sel ? {5'h0, power_state} : rail_enable});
    endtask
    // A skipped or reordered slot never shows the expected partial pattern.
    task automatic ramp(input logic down, input logic [2:0] st);
        logic [7:0] up [5] = '{8'h02, 8'h06, 8'h0e, 8'h1e, 8'h3e};
        for (int i = 0; i < 5; i++)
            wait_eq(1'b0, down ? (i == 4 ? 8'h00 : up[3 - i]) : up[i]);
        wait_eq(1'b1, {5'h0, st});
    endtask
    task automatic conclude;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        conclude;
    end
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        wait_eq(1'b1, 8'h02);
        wait_eq(1'b0, 8'h00);
        repeat (10) @(posedge pclk);
        acc(1'b1, pss_pkg::A_RTC, 32'h0000_0100, 1'b0);
        repeat (16) @(posedge pclk);
        acc(1'b0, pss_pkg::A_RTC, 32'h0000_0101, 1'b0);
        acc(1'b0, pss_pkg::A_ON_SLOT, 32'h0054_3210, 1'b0);
        acc(1'b0, 12'h02c, 32'h0, 1'b1);
        acc(1'b1, pss_pkg::A_SLP_SLOT, 32'h0000_0010, 1'b0);
        acc(1'b1, pss_pkg::A_GAP, 32'h0000_0003, 1'b0);
        acc(1'b0, pss_pkg::A_SLP_SLOT, 32'h0000_0010, 1'b0);
        acc(1'b1, pss_pkg::A_CTRL, 32'h1, 1'b0);
        ramp(1'b0, 3'h3);
        acc(1'b1, pss_pkg::A_GPIO, 32'h3, 1'b0);
        acc(1'b1, pss_pkg::A_SCRATCH, 32'h5a5a_a5a5, 1'b0);
        chk("gpio out", 32'h3, {30'h0, gpio_ext_enable});
        acc(1'b1, pss_pkg::A_DVS, 32'h0000_0022, 1'b0);
        repeat (4) @(posedge pclk);
        chk("dvs level", 32'h22, {24'h0, dvs_level});
        gpio_dvs_req <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("dvs gpio level", 32'h32, {24'h0, dvs_level});
        gpio_dvs_req <= 1'b0;
        $display("test power up done");
        acc(1'b1, pss_pkg::A_CTRL, 32'h4, 1'b0);
        wait_eq(1'b0, 8'h02);
        wait_eq(1'b1, 8'h04);
        acc(1'b1, pss_pkg::A_CTRL, 32'h8, 1'b0);
        ramp(1'b0, 3'h3);
        $display("test sleep done");
        acc(1'b1, pss_pkg::A_CTRL, 32'h2, 1'b0);
        acc(1'b1, pss_pkg::A_CTRL, 32'h1, 1'b0);
        ramp(1'b1, 3'h2);
        ramp(1'b0, 3'h3);
        $display("test held request done");
        watchdog_expired <= 1'b1;
        @(posedge pclk);
        watchdog_expired <= 1'b0;
        ramp(1'b1, 3'h2);
        power_on_n <= 1'b0;
        ramp(1'b0, 3'h3);
        power_on_n <= 1'b1;
        $display("test triggers done");
        acc(1'b1, pss_pkg::A_CTRL, 32'h20, 1'b0);
        acc(1'b1, pss_pkg::A_RTC, 32'h0000_0200, 1'b0);
        system_supply_ok <= 1'b0;
        wait_eq(1'b1, 8'h01);
        wait_eq(1'b0, 8'h00);
        repeat (20) @(posedge pclk);
        acc(1'b0, pss_pkg::A_RTC, 32'h0000_0200, 1'b0);
        system_supply_ok <= 1'b1;
        wait_eq(1'b1, 8'h02);
        acc(1'b0, pss_pkg::A_SCRATCH, 32'h5a5a_a5a5, 1'b0);
        acc(1'b0, pss_pkg::A_GAP, 32'h0000_000a, 1'b0);
        acc(1'b1, pss_pkg::A_PROG, {16'h0, pss_pkg::PROG_KEY1}, 1'b0);
        acc(1'b1, pss_pkg::A_PROG, {16'h0, pss_pkg::PROG_KEY2}, 1'b0);
        wait_eq(1'b1, 8'h05);
        acc(1'b1, pss_pkg::A_PROG, 32'h0, 1'b0);
        wait_eq(1'b1, 8'h02);
        supply_above_por <= 1'b0;
        wait_eq(1'b1, 8'h00);
        $display("test supplies done");
        conclude;
    end
endmodule
bind pss_sequencer pss_sequencer_chk chk (.pclk, .presetn, .supply_above_por, .system_supply_ok,
    .rail_enable, .alive_domain_regulator_en, .sys_reset_n, .power_state, .seq_busy,
    .gpio_ext_enable);
`default_nettype wire

// ---- pss_host.sv ----
// Host model: an APB master whose transfers the bench starts through xfer.
// Assumes one clock; each transfer starts one edge after the call.
`timescale 1ns/10ps
`default_nettype none
module pss_host (
    // Clock and answer.
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // Request.
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // Waiting an edge first keeps a release and the next setup out of one time step.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- pss_pkg.sv ----
// Package for the power state sequencer: register map, field layouts, timing constants.
// Assumes a single 10 MHz APB clock domain; all users refer to items as pss_pkg::name.
package pss_pkg;

    localparam int          NUM_RAILS   = 8;
    localparam int          NUM_SLOTS   = 5;
    localparam int          SLOT_W      = 3;
    localparam int          VSEL_W      = 8;

    // Register byte offsets.
    localparam logic [11:0] A_CTRL      = 12'h000;
    localparam logic [11:0] A_STATUS    = 12'h004;
    localparam logic [11:0] A_ON_SLOT   = 12'h008;
    localparam logic [11:0] A_SLP_SLOT  = 12'h00c;
    localparam logic [11:0] A_GAP       = 12'h010;
    localparam logic [11:0] A_DVS       = 12'h014;
    localparam logic [11:0] A_RTC       = 12'h018;
    localparam logic [11:0] A_SCRATCH   = 12'h01c;
    localparam logic [11:0] A_CFG_SRC   = 12'h020;
    localparam logic [11:0] A_GPIO      = 12'h024;
    localparam logic [11:0] A_PROG      = 12'h028;

    // Control register bits.
    localparam int          C_REQ_ON    = 0;
    localparam int          C_REQ_OFF   = 1;
    localparam int          C_REQ_SLEEP = 2;
    localparam int          C_REQ_WAKE  = 3;
    localparam int          C_ALIVE_OFF = 4;
    localparam int          C_UNCLOCKED = 5;
    localparam int          C_WDOG_OFF  = 6;

    // Slot word: one 4-bit nibble per rail, slot 0 means never enabled.
    localparam int          NIB_W       = 4;

    // Program-state key sequence.
    localparam logic [15:0] PROG_KEY1   = 16'h9716;
    localparam logic [15:0] PROG_KEY2   = 16'h6917;

    localparam logic [31:0] RESET_ON_SLOT  = 32'h5432_1111;
    localparam logic [31:0] RESET_SLP_SLOT = 32'h0000_0000;
    localparam logic [15:0] RESET_GAP      = 16'h000a;
    localparam logic [7:0]  RESET_DVS_V    = 8'h20;
    localparam logic [7:0]  RESET_DVS_RATE = 8'h04;

    // RTC advances at 1 Hz from the 10 MHz clock.
    localparam int          CLK_HZ      = 10_000_000;
    localparam int          RTC_PERIOD_S = 1;
    localparam int          RTC_DIV     = CLK_HZ * RTC_PERIOD_S;

    typedef enum logic [2:0]
    {
        PSS_NOPOWER = 3'b000,
        PSS_BACKUP  = 3'b001,
        PSS_OFF     = 3'b010,
        PSS_ON      = 3'b011,
        PSS_SLEEP   = 3'b100,
        PSS_PROGRAM = 3'b101
    } pss_state_e;

    typedef enum logic [1:0]
    {
        SEQ_IDLE = 2'b00,
        SEQ_STEP = 2'b01,
        SEQ_GAP  = 2'b10
    } pss_seq_e;

endpackage

// ---- pss_sequencer.sv ----
// Power state sequencer: main state machine, timeslot sequencer, DYNAMIC_VOLTAGE_SLEW slew, APB registers.
// Assumes APB on pclk; supply comparators and OTP/EEPROM config words arrive as
// synchronous levels from the analogue and memory loaders.
`timescale 1ns/10ps
`default_nettype none
module pss_sequencer #(
    parameter int RTC_DIV = pss_pkg::RTC_DIV
)(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Supply monitors and triggers.
    input  wire logic        supply_above_por,
    input  wire logic        system_supply_ok,
    input  wire logic        power_on_n,
    input  wire logic        watchdog_expired,
    // Configuration sources.
    input  wire logic        otp_valid,
    input  wire logic [31:0] otp_on_slot,
    input  wire logic [31:0] otp_slp_slot,
    input  wire logic        eeprom_present,
    input  wire logic        eeprom_valid,
    input  wire logic [31:0] eeprom_on_slot,
    input  wire logic [31:0] eeprom_slp_slot,
    // GPIO functions.
    input  wire logic        gpio_dvs_req,
    input  wire logic        gpio_sleep_req,
    output logic      [1:0]  gpio_ext_enable,
    // Rail controls, reset and status.
    output logic      [7:0]  rail_enable,
    output logic             alive_domain_regulator_en,
    output logic             internal_core_supply_regulator_en,
    output logic      [7:0]  dvs_level,
    output logic             sys_reset_n,
    output logic      [2:0]  power_state,
    output logic             seq_busy
);

    localparam int N = pss_pkg::NUM_RAILS;

    if (RTC_DIV < 2)
    begin : g_rtc_div_check
        $error("RTC_DIV must be at least 2.");
    end

    function automatic logic [3:0] slot_of(input logic [31:0] w, input int i);
        slot_of = w[i*pss_pkg::NIB_W +: pss_pkg::NIB_W];
    endfunction

    pss_pkg::pss_state_e state;
    pss_pkg::pss_state_e target;
    pss_pkg::pss_seq_e   seq;
    logic [31:0] on_slot;
    logic [31:0] slp_slot;
    logic [15:0] gap;
    logic [15:0] gap_cnt;
    logic [2:0]  slot;
    logic        seq_up;
    logic [31:0] seq_map;
    logic [7:0]  ctrl;
    logic [7:0]  dvs_target;
    logic [7:0]  dvs_rate;
    logic [7:0]  dvs_cnt;
    logic [31:0] rtc;
    logic [31:0] rtc_div;
    logic [31:0] scratch;
    logic [1:0]  gpio_out;
    logic [1:0]  prog_step;
    logic        cfg_loaded;
    logic [3:0]  pend;
    logic        pon_prev;

    // Bus decode.
    wire        wr_en   = psel && penable && pwrite;
    wire        is_ctrl = paddr == pss_pkg::A_CTRL;
    wire        mapped  = paddr <= pss_pkg::A_PROG && paddr[1:0] == 2'b00;
    wire        in_off  = state == pss_pkg::PSS_OFF;
    wire        cmd_on  = wr_en && is_ctrl && pwdata[pss_pkg::C_REQ_ON];
    wire        cmd_off = wr_en && is_ctrl && pwdata[pss_pkg::C_REQ_OFF];
    wire        cmd_slp = wr_en && is_ctrl && pwdata[pss_pkg::C_REQ_SLEEP];
    wire        cmd_wak = wr_en && is_ctrl && pwdata[pss_pkg::C_REQ_WAKE];
    wire        pon_fall = pon_prev && !power_on_n;
    wire        wd_fire  = watchdog_expired && !ctrl[pss_pkg::C_WDOG_OFF];
    wire        seq_idle = seq == pss_pkg::SEQ_IDLE;
    wire        backup_cond = !system_supply_ok;
    wire [31:0] src_on  = (eeprom_present && eeprom_valid) ? eeprom_on_slot  : otp_on_slot;
    wire [31:0] src_slp = (eeprom_present && eeprom_valid) ? eeprom_slp_slot : otp_slp_slot;
    wire        cfg_avail = otp_valid || (eeprom_present && eeprom_valid);
    wire        rtc_tick  = rtc_div == RTC_DIV - 1;
    wire        rtc_run   = state != pss_pkg::PSS_NOPOWER &&
                            !(state == pss_pkg::PSS_BACKUP && ctrl[pss_pkg::C_UNCLOCKED]);
    wire        in_on     = state == pss_pkg::PSS_ON;
    wire        in_slp    = state == pss_pkg::PSS_SLEEP;
    wire [3:0]  req_in    = {cmd_wak, cmd_slp || (gpio_sleep_req && in_on),
                             cmd_off || wd_fire, cmd_on || pon_fall};
    // Off beats sleep and wake; a request that is not legal in this state stays pending until the next sequence starts, unless PROGRAM, backup or no-power clears it.
    wire        go_off    = seq_idle && (in_on || in_slp) && pend[1];
    wire        go_slp    = seq_idle && in_on && pend[2];
    wire        go_up     = seq_idle && !go_off &&
                            ((in_off && pend[0]) || (in_slp && (pend[3] || pend[0])));
    wire        go_any    = go_off || go_slp || go_up;
    wire [2:0]  go_tgt    = go_off ? pss_pkg::PSS_OFF :
                            (go_slp ? pss_pkg::PSS_SLEEP : pss_pkg::PSS_ON);

    // Rails whose slot equals the current slot switch at this step; sleep keeps nonzero slots.
    logic [7:0] slot_hit;
    logic [7:0] sleep_keep;
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            slot_hit[i]   = slot_of(seq_map, i) == {1'b0, slot};
            sleep_keep[i] = slot_of(slp_slot, i) != 4'h0;
        end
    end

    wire [2:0] next_slot = seq_up ? slot + 3'h1 : slot - 3'h1;
    wire       last_slot = seq_up ? slot == 3'(pss_pkg::NUM_SLOTS) : slot == 3'h1;

    wire [31:0] status = {24'h0, cfg_loaded, pend[3:0] != 4'h0, !seq_idle, 1'b0,
                          power_on_n, state};
    wire [31:0] rd_mux =
        paddr == pss_pkg::A_CTRL     ? {24'h0, ctrl} :
        paddr == pss_pkg::A_STATUS   ? status :
        paddr == pss_pkg::A_ON_SLOT  ? on_slot :
        paddr == pss_pkg::A_SLP_SLOT ? slp_slot :
        paddr == pss_pkg::A_GAP      ? {16'h0, gap} :
        paddr == pss_pkg::A_DVS      ? {8'h0, dvs_level, dvs_rate, dvs_target} :
        paddr == pss_pkg::A_RTC      ? rtc :
        paddr == pss_pkg::A_SCRATCH  ? scratch :
        paddr == pss_pkg::A_CFG_SRC  ? {30'h0, eeprom_present && eeprom_valid, otp_valid} :
        paddr == pss_pkg::A_GPIO     ? {28'h0, gpio_sleep_req, gpio_dvs_req, gpio_out} :
        {30'h0, prog_step};

    // APB answers in the access cycle; unmapped addresses report an error.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite && mapped) ? rd_mux : 32'h0;
        end
    end

    wire acc = psel && penable && pready;
    wire wr  = acc && pwrite;

    // RTC and scratch survive backup; only no-power clears them.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rtc     <= 32'h0;
            rtc_div <= 32'h0;
            scratch <= 32'h0;
        end
        else if (!supply_above_por)
        begin
            rtc     <= 32'h0;
            rtc_div <= 32'h0;
            scratch <= 32'h0;
        end
        else
        begin
            if (wr && paddr == pss_pkg::A_SCRATCH)
            begin
                scratch <= pwdata;
            end
            if (wr && paddr == pss_pkg::A_RTC)
            begin
                rtc     <= pwdata;
                rtc_div <= 32'h0;
            end
            else if (rtc_run)
            begin
                rtc_div <= rtc_tick ? 32'h0 : rtc_div + 32'h1;
                rtc     <= rtc_tick ? rtc + 32'h1 : rtc;
            end
        end
    end

    // Main state, register file and sequencer.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state      <= pss_pkg::PSS_NOPOWER;
            target     <= pss_pkg::PSS_NOPOWER;
            seq        <= pss_pkg::SEQ_IDLE;
            on_slot    <= pss_pkg::RESET_ON_SLOT;
            slp_slot   <= pss_pkg::RESET_SLP_SLOT;
            gap        <= pss_pkg::RESET_GAP;
            gap_cnt    <= 16'h0;
            slot       <= 3'h0;
            seq_up     <= 1'b0;
            seq_map    <= 32'h0;
            ctrl       <= 8'h0;
            dvs_target <= pss_pkg::RESET_DVS_V;
            dvs_rate   <= pss_pkg::RESET_DVS_RATE;
            gpio_out   <= 2'b00;
            prog_step  <= 2'b00;
            cfg_loaded <= 1'b0;
            pend       <= 4'h0;
            pon_prev   <= 1'b1;
            rail_enable <= 8'h0;
        end
        else if (!supply_above_por)
        begin
            state       <= pss_pkg::PSS_NOPOWER;
            seq         <= pss_pkg::SEQ_IDLE;
            rail_enable <= 8'h0;
            pend        <= 4'h0;
            cfg_loaded  <= 1'b0;
            ctrl        <= 8'h0;
            on_slot     <= pss_pkg::RESET_ON_SLOT;
            slp_slot    <= pss_pkg::RESET_SLP_SLOT;
            prog_step   <= 2'b00;
        end
        else if (backup_cond)
        begin
            state       <= pss_pkg::PSS_BACKUP;
            seq         <= pss_pkg::SEQ_IDLE;
            rail_enable <= 8'h0;
            pend        <= 4'h0;
            cfg_loaded  <= 1'b0;
            gpio_out    <= 2'b00;
            gap         <= pss_pkg::RESET_GAP;
            dvs_target  <= pss_pkg::RESET_DVS_V;
            dvs_rate    <= pss_pkg::RESET_DVS_RATE;
            ctrl        <= ctrl & (8'h1 << pss_pkg::C_UNCLOCKED);
            prog_step   <= 2'b00;
        end
        else
        begin
            pon_prev <= power_on_n;
            if (state == pss_pkg::PSS_NOPOWER || state == pss_pkg::PSS_BACKUP)
            begin
                state <= pss_pkg::PSS_OFF;
            end
            if (!cfg_loaded && cfg_avail)
            begin
                on_slot    <= src_on;
                slp_slot   <= src_slp;
                cfg_loaded <= 1'b1;
            end
            // Register writes; slot maps only change in OFF so a running sequence is stable.
            if (wr)
            begin
                case (paddr)
                    pss_pkg::A_CTRL:     ctrl <= {1'b0, pwdata[6:4], 4'h0};
                    pss_pkg::A_ON_SLOT:  if (in_off) on_slot <= pwdata;
                    pss_pkg::A_SLP_SLOT: if (in_off) slp_slot <= pwdata;
                    pss_pkg::A_GAP:      gap <= pwdata[15:0];
                    pss_pkg::A_DVS:      {dvs_rate, dvs_target} <= pwdata[15:0];
                    pss_pkg::A_GPIO:     gpio_out <= pwdata[1:0];
                    pss_pkg::A_PROG:
                        if (in_off && prog_step == 2'b00 && pwdata[15:0] == pss_pkg::PROG_KEY1)
                            prog_step <= 2'b01;
                        else if (prog_step == 2'b01 && pwdata[15:0] == pss_pkg::PROG_KEY2)
                            prog_step <= 2'b10;
                        else
                            prog_step <= 2'b00;
                    default: ;
                endcase
            end
            if (prog_step == 2'b10 && in_off)
            begin
                state     <= pss_pkg::PSS_PROGRAM;
                prog_step <= 2'b11;
            end
            else if (state == pss_pkg::PSS_PROGRAM && prog_step == 2'b00)
            begin
                state <= pss_pkg::PSS_OFF;
            end
            // Latch requests: on, off, sleep, wake. Held while a sequence runs.
            pend <= pend | req_in;
            case (seq)
                pss_pkg::SEQ_IDLE:
                    if (go_any)
                    begin
                        pend    <= req_in;
                        target  <= pss_pkg::pss_state_e'(go_tgt);
                        seq_map <= on_slot;
                        seq_up  <= go_up;
                        slot    <= go_up ? 3'h1 : 3'(pss_pkg::NUM_SLOTS);
                        seq     <= pss_pkg::SEQ_STEP;
                    end
                    else if (state == pss_pkg::PSS_PROGRAM)
                    begin
                        pend <= 4'h0;
                    end
                pss_pkg::SEQ_STEP:
                begin
                    // each slot's rails switch together, then wait the gap before the next slot.
                    for (int i = 0; i < N; i++)
                    begin
                        if (slot_hit[i])
                        begin
                            if (seq_up)
                                rail_enable[i] <= 1'b1;
                            else if (!(target == pss_pkg::PSS_SLEEP && sleep_keep[i]))
                                rail_enable[i] <= 1'b0;
                        end
                    end
                    gap_cnt <= gap;
                    seq <= last_slot ? pss_pkg::SEQ_IDLE : pss_pkg::SEQ_GAP;
                    if (last_slot)
                    begin
                        state <= target;
                    end
                end
                pss_pkg::SEQ_GAP:
                    if (gap_cnt == 16'h0)
                    begin
                        slot <= next_slot;
                        seq <= pss_pkg::SEQ_STEP;
                    end
                    else
                    begin
                        gap_cnt <= gap_cnt - 16'h1;
                    end
                default: seq <= pss_pkg::SEQ_IDLE;
            endcase
        end
    end

    // Slew the fast buck level one step every dvs_rate+1 cycles.
    wire [7:0] dvs_goal = gpio_dvs_req ? dvs_target + 8'h10 : dvs_target;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dvs_level <= pss_pkg::RESET_DVS_V;
            dvs_cnt   <= 8'h0;
        end
        else if (dvs_level != dvs_goal)
        begin
            dvs_cnt <= dvs_cnt == dvs_rate ? 8'h0 : dvs_cnt + 8'h1;
            if (dvs_cnt == dvs_rate)
            begin
                dvs_level <= dvs_level < dvs_goal ? dvs_level + 8'h1 : dvs_level - 8'h1;
            end
        end
        else
        begin
            dvs_cnt <= 8'h0;
        end
    end

    // Registered outputs.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sys_reset_n                       <= 1'b0;
            alive_domain_regulator_en         <= 1'b0;
            internal_core_supply_regulator_en <= 1'b0;
            power_state                       <= 3'h0;
            seq_busy                          <= 1'b0;
            gpio_ext_enable                   <= 2'b00;
        end
        else
        begin
            sys_reset_n <= state == pss_pkg::PSS_ON || state == pss_pkg::PSS_SLEEP;
            alive_domain_regulator_en <= (state == pss_pkg::PSS_OFF &&
                !ctrl[pss_pkg::C_ALIVE_OFF]) || state == pss_pkg::PSS_ON ||
                state == pss_pkg::PSS_SLEEP;
            internal_core_supply_regulator_en <= state != pss_pkg::PSS_NOPOWER &&
                state != pss_pkg::PSS_BACKUP;
            power_state     <= state;
            seq_busy        <= !seq_idle;
            gpio_ext_enable <= (state == pss_pkg::PSS_ON) ? gpio_out : 2'b00;
        end
    end

endmodule
`default_nettype wire

// ---- pss_sequencer_sva.sv ----
// Port checker for the power state sequencer.
// Assumes it is bound to the sequencer top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module pss_sequencer_chk (
    // Clock and reset.
    input wire logic       pclk,
    input wire logic       presetn,
    // Supply monitors.
    input wire logic       supply_above_por,
    input wire logic       system_supply_ok,
    // Outputs watched.
    input wire logic [7:0] rail_enable,
    input wire logic       alive_domain_regulator_en,
    input wire logic       sys_reset_n,
    input wire logic [2:0] power_state,
    input wire logic       seq_busy,
    input wire logic [1:0] gpio_ext_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // States are checked on their second cycle so that registered outputs may lag by one.
    off_reset_low_a: assert property (power_state == 3'h2 ##1 power_state == 3'h2 |-> !sys_reset_n)
        else $error("reset output high while off");
    off_rails_dark_a: assert property (power_state == 3'h2 && !seq_busy ##1 power_state == 3'h2 && !seq_busy |-> rail_enable == 8'h00)
        else $error("rail enabled while off and idle");
    on_reset_high_a: assert property (power_state == 3'h3 ##1 power_state == 3'h3 |-> sys_reset_n)
        else $error("reset output low while on");
    backup_dark_a: assert property (power_state == 3'h1 ##1 power_state == 3'h1 |-> rail_enable == 8'h00 && !alive_domain_regulator_en)
        else $error("rail enabled in backup");
    nopower_dark_a: assert property (power_state == 3'h0 ##1 power_state == 3'h0 |-> rail_enable == 8'h00 && !sys_reset_n)
        else $error("output active with no power");
    backup_entry_a: assert property (supply_above_por && !system_supply_ok |-> ##[1:3] power_state == 3'h1)
        else $error("backup not entered on supply loss");
    por_hold_a: assert property (!supply_above_por |-> ##[1:3] power_state == 3'h0)
        else $error("no power state not forced");
    backup_exit_a: assert property (power_state == 3'h1 && system_supply_ok && supply_above_por |-> ##[1:3] power_state != 3'h1)
        else $error("backup not left when supply returned");
    gpio_out_a: assert property (power_state != 3'h3 ##1 power_state != 3'h3 |-> gpio_ext_enable == 2'h0)
        else $error("gpio output active outside on");
endmodule
`default_nettype wire
